/* tw_pkg.sv */
/*
  tw_pkg: register offsets, field positions, reset values and mode
  codes shared by the 8-bit timer with two waveform channels.
  Assumes a byte-wide register port with printed offsets used as is.
*/
package tw_pkg;
    // register offsets
    localparam logic [7:0] OFS_CTRL_B = 8'h18;
    localparam logic [7:0] OFS_CTRL_A = 8'h19;
    localparam logic [7:0] OFS_COUNT = 8'h1a;
    localparam logic [7:0] OFS_CMP_A = 8'h1b;
    localparam logic [7:0] OFS_CMP_B = 8'h1c;
    localparam logic [7:0] OFS_FLAGS = 8'h1d;

    // values after reset
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_ACT = 2'h0;
    localparam logic [2:0] RST_CS = 3'h0;

    // control a fields
    localparam int CA_ACT_A_LSB = 6;
    localparam int CA_ACT_B_LSB = 4;
    localparam int CA_WGM_LSB = 0;
    // control b fields
    localparam int CB_FORCE_A = 7;
    localparam int CB_FORCE_B = 6;
    localparam int CB_SYNC_HOLD = 5;
    localparam int CB_PRE_RESET = 4;
    localparam int CB_TOP_BIT = 3;
    localparam int CB_CS_LSB = 0;
    // flag register fields
    localparam int FL_MATCH_B = 2;
    localparam int FL_MATCH_A = 1;
    localparam int FL_OVF = 0;

    // counter landmarks
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // waveform generation modes
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_PHASE_FF = 3'h1;
    localparam logic [2:0] MODE_CTC = 3'h2;
    localparam logic [2:0] MODE_FAST_FF = 3'h3;
    localparam logic [2:0] MODE_PHASE_CA = 3'h5;
    localparam logic [2:0] MODE_FAST_CA = 3'h7;

    // clock select and output action codes
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // prescaler tap masks, all ones once every n clocks
    localparam int PRE_W = 10;
    localparam logic [9:0] PRE_MASK_8 = 10'h007;
    localparam logic [9:0] PRE_MASK_64 = 10'h03f;
    localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
    localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
endpackage : tw_pkg

/* tw_timer0.sv */
/*
  tw_timer0: 8-bit timer/counter with two compare channels, clock
  select with prescaler or external count pin, and waveform outputs.
  Assumes a single 25 MHz clock, a byte register port with one-cycle
  strobes, and a port block that honours the output enables.
*/
// The plain strobed port is this design's own decision.
// Overview of operation
// [R1] action field plus direction drives pin
// [R2] non-PWM: off, toggle, clear, set
// [R3] fast PWM: match level, opposite at bottom
// [R4] fast PWM compare at top: act at bottom
// [R5] phase PWM: action follows count direction
// [R6] phase PWM compare at top: act at top
// [R7] control a bits 3:2 read zero
// [R8] mode is top bit plus two bits
// [R9] modes 0,1,2: top, update, overflow
// [R10] modes 3,5,7 defined; 4, 6 reserved
// [R11] max 0xff, bottom 0x00
// [R12] forces act only in non-PWM modes
// [R13] software writes force zero in PWM
// [R14] force sets no flag, clears nothing
// [R15] force bits read zero
// [R16] clock select: stop, direct, prescaler taps
// [R17] external pin falling or rising edges
// [R18] external edges count when pin outputs
// [R19] counter write blocks next match
// [R20] running counter writes may miss matches
// [R21] compare a checked every timer clock
// [R22] compare b checked every timer clock
// [R23] match flags set by hardware, one clears
// [R24] phase PWM holds top one clock
// [R25] overflow point depends on mode
// [R26] clear-on-match top is compare a
`timescale 1ns/100ps
module tw_timer0 #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_count_pin,
    input wire logic pin_dir_a,
    input wire logic pin_dir_b,
    input wire logic [2:0] vector_clear,
    output logic wave_out_a,
    output logic wave_oe_a,
    output logic wave_out_b,
    output logic wave_oe_b,
    output logic match_flag_a,
    output logic match_flag_b,
    output logic overflow_flag
);
    // refuse an address too narrow for the register map
    if (ADDR_W < 5) begin : g_addr_check
        $error("tw_timer0: ADDR_W must be at least 5");
    end
    logic [1:0] out_a_match_action_q, out_b_match_action_q;
    logic [1:0] wave_gen_select_q;
    logic [2:0] count_clock_select_q, mode, flags_q;
    logic [7:0] count_value_q, compare_value_a_q, compare_value_b_q;
    logic [7:0] cmp_a_live_q, cmp_b_live_q, top, rd_mux;
    logic [tw_pkg::PRE_W-1:0] pre_q;
    logic wave_gen_top_bit_q, sync_hold_q, pre_reset_q, count_up_q;
    logic block_match_q, ext_s1_q, ext_s2_q, ext_s3_q, wave_a_q, wave_b_q;
    logic fast_pwm, phase_pwm, non_pwm, tick, at_top, wr_ctrl_a, wr_ctrl_b;
    logic wr_count, wr_flags, force_a, force_b, match_a, match_b, ovf_event;
    // register write decode
    assign wr_ctrl_a = reg_wr && (reg_addr == ADDR_W'(tw_pkg::OFS_CTRL_A));
    assign wr_ctrl_b = reg_wr && (reg_addr == ADDR_W'(tw_pkg::OFS_CTRL_B));
    assign wr_count = reg_wr && (reg_addr == ADDR_W'(tw_pkg::OFS_COUNT));
    assign wr_flags = reg_wr && (reg_addr == ADDR_W'(tw_pkg::OFS_FLAGS));

    // [R8] mode assembly
    assign mode = {wave_gen_top_bit_q, wave_gen_select_q};
    // [R10] mode classes, reserved modes fall in none of the three
    assign fast_pwm = (mode == tw_pkg::MODE_FAST_FF) ||
                      (mode == tw_pkg::MODE_FAST_CA);
    assign phase_pwm = (mode == tw_pkg::MODE_PHASE_FF) ||
                       (mode == tw_pkg::MODE_PHASE_CA);
    assign non_pwm = (mode == tw_pkg::MODE_NORMAL) ||
                     (mode == tw_pkg::MODE_CTC);

    // [R26] top source per mode
    always_comb begin
        case (mode)
            tw_pkg::MODE_CTC,
            tw_pkg::MODE_PHASE_CA,
            tw_pkg::MODE_FAST_CA: top = cmp_a_live_q;
            default: top = tw_pkg::CNT_MAX;
        endcase
    end

    // [R12] forces only in non-PWM modes
    assign force_a = wr_ctrl_b && reg_wdata[tw_pkg::CB_FORCE_A] && non_pwm;
    assign force_b = wr_ctrl_b && reg_wdata[tw_pkg::CB_FORCE_B] && non_pwm;

    // external pin synchroniser, third stage for edge detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= ext_count_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end

    // prescaler, held cleared while a reset request is pending or held
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_q <= '0;
        end else if (pre_reset_q) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // [R16] [R17] timer clock select
    always_comb begin
        case (count_clock_select_q)
            tw_pkg::CS_STOP: tick = 1'b0;
            tw_pkg::CS_DIV1: tick = 1'b1;
            tw_pkg::CS_DIV8: tick = &(pre_q | ~tw_pkg::PRE_MASK_8);
            tw_pkg::CS_DIV64: tick = &(pre_q | ~tw_pkg::PRE_MASK_64);
            tw_pkg::CS_DIV256: tick = &(pre_q | ~tw_pkg::PRE_MASK_256);
            tw_pkg::CS_DIV1024: tick = &(pre_q | ~tw_pkg::PRE_MASK_1024);
            // [R18] pin is watched whatever its direction
            tw_pkg::CS_EXT_FALL: tick = ext_s3_q && !ext_s2_q;
            tw_pkg::CS_EXT_RISE: tick = ext_s2_q && !ext_s3_q;
            default: tick = 1'b0;
        endcase
    end

    assign at_top = tick && (count_value_q == top);
    // [R21] [R22] compare on each timer clock; [R19] blocked after write
    assign match_a = tick && !block_match_q &&
                     (count_value_q == cmp_a_live_q);
    assign match_b = tick && !block_match_q &&
                     (count_value_q == cmp_b_live_q);

    // [R25] [R9] [R11] overflow point by mode
    always_comb begin
        if (phase_pwm) begin
            ovf_event = tick && !count_up_q &&
                        (count_value_q == tw_pkg::CNT_BOTTOM);
        end else if (mode == tw_pkg::MODE_FAST_CA) begin
            ovf_event = at_top;
        end else begin
            ovf_event = tick && (count_value_q == tw_pkg::CNT_MAX);
        end
    end

    // control registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_a_match_action_q <= tw_pkg::RST_ACT;
            out_b_match_action_q <= tw_pkg::RST_ACT;
            wave_gen_select_q <= 2'h0;
            wave_gen_top_bit_q <= 1'b0;
            count_clock_select_q <= tw_pkg::RST_CS;
            sync_hold_q <= 1'b0;
            pre_reset_q <= 1'b0;
        end else begin
            if (wr_ctrl_a) begin
                out_a_match_action_q <= reg_wdata[tw_pkg::CA_ACT_A_LSB +: 2];
                out_b_match_action_q <= reg_wdata[tw_pkg::CA_ACT_B_LSB +: 2];
                wave_gen_select_q <= reg_wdata[tw_pkg::CA_WGM_LSB +: 2];
            end
            if (wr_ctrl_b) begin
                sync_hold_q <= reg_wdata[tw_pkg::CB_SYNC_HOLD];
                pre_reset_q <= reg_wdata[tw_pkg::CB_PRE_RESET];
                wave_gen_top_bit_q <= reg_wdata[tw_pkg::CB_TOP_BIT];
                count_clock_select_q <= reg_wdata[tw_pkg::CB_CS_LSB +: 3];
            end else if (!sync_hold_q) begin
                pre_reset_q <= 1'b0; // reset request clears itself
            end
        end
    end

    // compare registers and their live copies
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            compare_value_a_q <= tw_pkg::RST_BYTE;
            compare_value_b_q <= tw_pkg::RST_BYTE;
            cmp_a_live_q <= tw_pkg::RST_BYTE;
            cmp_b_live_q <= tw_pkg::RST_BYTE;
        end else begin
            if (reg_wr && (reg_addr == ADDR_W'(tw_pkg::OFS_CMP_A))) begin
                compare_value_a_q <= reg_wdata;
            end
            if (reg_wr && (reg_addr == ADDR_W'(tw_pkg::OFS_CMP_B))) begin
                compare_value_b_q <= reg_wdata;
            end
            // [R9] [R10] PWM copies load at top, others at once
            if (!(fast_pwm || phase_pwm) || at_top) begin
                cmp_a_live_q <= compare_value_a_q;
                cmp_b_live_q <= compare_value_b_q;
            end
        end
    end

    // counter and direction
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_value_q <= tw_pkg::RST_BYTE;
            count_up_q <= 1'b1;
        end else if (wr_count) begin
            // [R19] software write takes the counter
            count_value_q <= reg_wdata;
        end else if (tick) begin
            if (phase_pwm) begin
                // [R24] top and bottom each last one timer clock
                if (count_up_q && (count_value_q == top)) begin
                    count_value_q <= count_value_q - 1'b1;
                    count_up_q <= 1'b0;
                end else if (!count_up_q &&
                             (count_value_q == tw_pkg::CNT_BOTTOM)) begin
                    count_value_q <= count_value_q + 1'b1;
                    count_up_q <= 1'b1;
                end else if (count_up_q) begin
                    count_value_q <= count_value_q + 1'b1;
                end else begin
                    count_value_q <= count_value_q - 1'b1;
                end
            end else if (at_top) begin
                // [R14] only the count reaching top clears, never a force
                count_value_q <= tw_pkg::CNT_BOTTOM;
                count_up_q <= 1'b1;
            end else begin
                count_value_q <= count_value_q + 1'b1;
                count_up_q <= 1'b1;
            end
        end
    end

    // [R19] match block held until the next timer clock
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            block_match_q <= 1'b0;
        end else if (wr_count) begin
            block_match_q <= 1'b1;
        end else if (tick) begin
            block_match_q <= 1'b0;
        end
    end

    // next level of a waveform output
    function automatic logic wave_next(
        input logic cur, input logic [1:0] act, input logic match,
        input logic force_m, input logic cmp_top, input logic tog_ok,
        input logic is_fast, input logic is_phase, input logic is_plain,
        input logic top_ev, input logic up
    );
        logic nv;
        nv = cur;
        if (is_plain) begin
            // [R2] non-PWM action table, forces behave as matches
            if (match || force_m) begin
                case (act)
                    tw_pkg::ACT_TOGGLE: nv = ~cur;
                    tw_pkg::ACT_CLEAR: nv = 1'b0;
                    tw_pkg::ACT_SET: nv = 1'b1;
                    default: nv = cur;
                endcase
            end
        end else if (is_fast && act[1]) begin
            // [R4] compare at top: level set only at bottom
            if (cmp_top) begin
                if (top_ev) nv = ~act[0];
            // [R3] match level, opposite level at bottom
            end else if (match) begin
                nv = act[0];
            end else if (top_ev) begin
                nv = ~act[0];
            end
        end else if (is_phase && act[1]) begin
            // [R6] compare at top: up-count level applied at top
            if (cmp_top) begin
                if (top_ev && up) nv = act[0];
            // [R5] level follows count direction
            end else if (match) begin
                nv = up ? act[0] : ~act[0];
            end
        end else if ((is_fast || is_phase) && act == tw_pkg::ACT_TOGGLE) begin
            if (tog_ok && match) nv = ~cur; // toggle on channel a only, and only with the top bit set
        end
        return nv;
    endfunction : wave_next

    // waveform levels and pin enables
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
            wave_oe_a <= 1'b0;
            wave_oe_b <= 1'b0;
        end else begin
            wave_a_q <= wave_next(wave_a_q, out_a_match_action_q, match_a,
                force_a, cmp_a_live_q == top, wave_gen_top_bit_q,
                fast_pwm, phase_pwm, non_pwm, at_top, count_up_q);
            wave_b_q <= wave_next(wave_b_q, out_b_match_action_q, match_b,
                force_b, cmp_b_live_q == top, 1'b0,
                fast_pwm, phase_pwm, non_pwm, at_top, count_up_q);
            // [R1] override needs action and direction
            wave_oe_a <= (out_a_match_action_q != tw_pkg::ACT_OFF) &&
                         pin_dir_a;
            wave_oe_b <= (out_b_match_action_q != tw_pkg::ACT_OFF) &&
                         pin_dir_b;
        end
    end

    assign wave_out_a = wave_a_q;
    assign wave_out_b = wave_b_q;

    // [R23] flags: hardware set wins over any clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flags_q <= 3'h0;
        end else begin
            // [R14] forces never reach the flags
            flags_q <= ((flags_q & ~(wr_flags ? reg_wdata[2:0] : 3'h0))
                        & ~vector_clear) |
                       {match_b, match_a, ovf_event};
        end
    end

    assign match_flag_b = flags_q[tw_pkg::FL_MATCH_B];
    assign match_flag_a = flags_q[tw_pkg::FL_MATCH_A];
    assign overflow_flag = flags_q[tw_pkg::FL_OVF];

    // read data selection, unmapped reads zero
    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            // [R7] reserved bits zero
            ADDR_W'(tw_pkg::OFS_CTRL_A):
                rd_mux = {out_a_match_action_q, out_b_match_action_q,
                          2'b00, wave_gen_select_q};
            // [R15] force bits read zero
            ADDR_W'(tw_pkg::OFS_CTRL_B):
                rd_mux = {2'b00, sync_hold_q, pre_reset_q,
                          wave_gen_top_bit_q, count_clock_select_q};
            ADDR_W'(tw_pkg::OFS_COUNT): rd_mux = count_value_q;
            ADDR_W'(tw_pkg::OFS_CMP_A): rd_mux = compare_value_a_q;
            ADDR_W'(tw_pkg::OFS_CMP_B): rd_mux = compare_value_b_q;
            ADDR_W'(tw_pkg::OFS_FLAGS): rd_mux = {5'h00, flags_q};
            default: rd_mux = 8'h00;
        endcase
    end

    // read data valid the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end
endmodule : tw_timer0

/* tw_timer0_sva.sv */
/*
  tw_timer0_sva: port-level properties of the timer, bound to tw_timer0.
  Assumes one clock clk and a synchronous active-low rst_n.
*/
`timescale 1ns/100ps
module tw_timer0_sva #(
    parameter int ADDR_W = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic ext_count_pin,
    input wire logic pin_dir_a,
    input wire logic pin_dir_b,
    input wire logic [2:0] vector_clear,
    input wire logic wave_out_a,
    input wire logic wave_oe_a,
    input wire logic wave_out_b,
    input wire logic wave_oe_b,
    input wire logic match_flag_a,
    input wire logic match_flag_b,
    input wire logic overflow_flag
);
    logic [7:0] ca_q;
    logic [7:0] cb_q;
    logic wr_ca;
    logic wr_cb;
    logic non_pwm;
    logic stop;

    // control write decode and the mode in force
    assign wr_ca = reg_wr && reg_addr == ADDR_W'(tw_pkg::OFS_CTRL_A);
    assign wr_cb = reg_wr && reg_addr == ADDR_W'(tw_pkg::OFS_CTRL_B);
    assign non_pwm = !cb_q[3] && !ca_q[0];
    assign stop = cb_q[2:0] == tw_pkg::CS_STOP;

    // shadow of control a
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ca_q <= tw_pkg::RST_BYTE;
        end else if (wr_ca) begin
            ca_q <= reg_wdata;
        end
    end

    // shadow of control b
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cb_q <= tw_pkg::RST_BYTE;
        end else if (wr_cb) begin
            cb_q <= reg_wdata;
        end
    end

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_oe_b;
        wave_oe_b == $past(ca_q[5:4] != 2'h0 && pin_dir_b);
    endproperty
    a_oe_b: assert property (p_oe_b)
        else $error("pin enable b wrong");
    property p_ca_rsv;
        reg_rd && reg_addr == ADDR_W'(tw_pkg::OFS_CTRL_A)
            |=> reg_rdata[3:2] == 2'h0;
    endproperty
    a_ca_rsv: assert property (p_ca_rsv)
        else $error("reserved bits read nonzero");
    property p_cb_frc;
        reg_rd && reg_addr == ADDR_W'(tw_pkg::OFS_CTRL_B)
            |=> reg_rdata[7:6] == 2'h0;
    endproperty
    a_cb_frc: assert property (p_cb_frc)
        else $error("force bits read nonzero");
    property p_rd_idle;
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside read slot");
    property p_force_np;
        wr_cb && reg_wdata[6] && !reg_wdata[3] && non_pwm && stop
            && ca_q[5:4] != tw_pkg::ACT_OFF |=> wave_out_b ==
            (ca_q[5:4] == tw_pkg::ACT_SET || (ca_q[5:4] ==
            tw_pkg::ACT_TOGGLE && !$past(wave_out_b)));
    endproperty
    a_force_np: assert property (p_force_np)
        else $error("forced match gave wrong level");
    property p_force_pwm;
        wr_cb && reg_wdata[6] && reg_wdata[3] == cb_q[3] && !non_pwm
            && stop |=> $stable(wave_out_b);
    endproperty
    a_force_pwm: assert property (p_force_pwm)
        else $error("force acted in pwm mode");
    property p_force_flag;
        wr_cb && reg_wdata[7:6] != 2'h0 && stop && !match_flag_a
            && !match_flag_b |=> !match_flag_a && !match_flag_b;
    endproperty
    a_force_flag: assert property (p_force_flag)
        else $error("force raised a flag");
    property p_w1c;
        reg_wr && reg_addr == ADDR_W'(tw_pkg::OFS_FLAGS)
            && reg_wdata[tw_pkg::FL_MATCH_B] && stop |=> !match_flag_b;
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("flag b not cleared by one");
    property p_hw_clr;
        vector_clear[0] && stop |=> !overflow_flag;
    endproperty
    a_hw_clr: assert property (p_hw_clr)
        else $error("overflow not cleared by vector");
endmodule : tw_timer0_sva

bind tw_timer0 tw_timer0_sva #(.ADDR_W(ADDR_W)) u_sva (
    .clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ext_count_pin, .pin_dir_a, .pin_dir_b, .vector_clear, .wave_out_a,
    .wave_oe_a, .wave_out_b, .wave_oe_b, .match_flag_a, .match_flag_b,
    .overflow_flag
);

/* testbench.sv */
/*
  testbench: self-checking bench for tw_timer0 over its register port.
  Assumes tw_pkg offsets and a 25 MHz clock.
*/
`timescale 1ns/100ps
module testbench;
    logic clk, rst_n, reg_wr, reg_rd, ext_count_pin, pin_dir_a, pin_dir_b;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv, d2;
    logic [2:0] vector_clear;
    logic wave_out_a, wave_oe_a, wave_out_b, wave_oe_b;
    logic match_flag_a, match_flag_b, overflow_flag;
    logic [1:0] pv;
    integer seed, n_fail, cmp_count, i;
    int divs[6] = '{0, 1, 8, 64, 256, 1024};
    localparam logic [7:0] CB = tw_pkg::OFS_CTRL_B, CA = tw_pkg::OFS_CTRL_A;
    localparam logic [7:0] CN = tw_pkg::OFS_COUNT, MA = tw_pkg::OFS_CMP_A;
    localparam logic [7:0] MB = tw_pkg::OFS_CMP_B, FL = tw_pkg::OFS_FLAGS;

    tw_timer0 #(.ADDR_W(8)) DUT (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .ext_count_pin(ext_count_pin),
        .pin_dir_a(pin_dir_a), .pin_dir_b(pin_dir_b),
        .vector_clear(vector_clear), .wave_out_a(wave_out_a),
        .wave_oe_a(wave_oe_a), .wave_out_b(wave_out_b),
        .wave_oe_b(wave_oe_b), .match_flag_a(match_flag_a),
        .match_flag_b(match_flag_b), .overflow_flag(overflow_flag)
    );

    // 40 ns clock
    always #20 clk = ~clk;

    // one-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    // one-cycle read, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    // compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk

    task automatic chkb(input logic ok);
        chk({7'h0, ok}, 8'h01);
    endtask : chkb

    // count undivided for n+2 clocks, then stop
    task automatic run(input int n);
        wr(CB, 8'h01);
        repeat (n) @(posedge clk);
        wr(CB, 8'h00);
    endtask : run

    // run a pwm mode on channel b and measure its high time
    task automatic duty(input logic [2:0] md, input logic [1:0] act,
        input logic [7:0] c);
        integer n;
        integer h;
        integer e;
        n = md[1] ? 512 : 1020;
        e = md[1] ? 2 * (c + 1) : 4 * c;
        if (act[0]) e = n - e;
        wr(MB, c);
        wr(CA, {2'h0, act, 2'h0, md[1:0]});
        wr(CB, {4'h0, md[2], tw_pkg::CS_DIV1}); // force bits zero
        repeat (600) @(posedge clk);
        h = 0;
        repeat (n) begin
            @(posedge clk);
            if (wave_out_b === 1'b1) h = h + 1;
        end
        wr(CB, 8'h00);
        chkb(h >= e - 6 && h <= e + 6);
    endtask : duty

    // verdict and end of run
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    // watchdog against a hang
    initial begin
        #1600000;
        n_fail = n_fail + 1;
        $display("MISMATCH at %0t: watchdog expired", $time);
        conclude();
    end

    // main sequence
    initial begin
        clk = 1'b0; rst_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
        reg_wr = 1'b0; reg_rd = 1'b0; ext_count_pin = 1'b0;
        pin_dir_a = 1'b0; pin_dir_b = 1'b0; vector_clear = 3'h0;
        seed = 32'hbbf9980c; n_fail = 0; cmp_count = 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i++) begin
            rd(CB + 8'(i), rv);
            chk(rv, 8'h00);
        end
        wr(CA, 8'hff);
        rd(CA, rv);
        chk(rv, 8'hf3);
        wr(CA, 8'h00);
        wr(CB, 8'hec);
        rd(CB, rv);
        chk(rv, 8'h2c);
        wr(CB, 8'h00);
        wr(8'h1e, 8'h5a);
        rd(8'h1e, rv);
        chk(rv, 8'h00);
        for (i = 0; i < 6; i++) begin
            rv = 8'($random(seed));
            wr(CN + 8'(i % 3), rv);
            rd(CN + 8'(i % 3), d2);
            chk(d2, rv);
        end
        for (i = 1; i < 6; i++) begin
            wr(CN, 8'h00); // counter written only while stopped
            wr(CB, 8'(i));
            repeat (4 * divs[i] - 2) @(posedge clk);
            wr(CB, 8'h00);
            rd(CN, rv);
            chk(rv, 8'h04);
        end
        pin_dir_a <= 1'b1;
        pin_dir_b <= 1'b1;
        for (i = 6; i < 8; i++) begin
            wr(CN, 8'h00);
            wr(CB, 8'(i));
            repeat (11) begin
                @(posedge clk);
                ext_count_pin <= ~ext_count_pin;
                repeat (5) @(posedge clk);
            end
            wr(CB, 8'h00);
            rd(CN, rv);
            chk(rv, (i == 7) ? 8'h06 : 8'h05);
            @(posedge clk);
            ext_count_pin <= 1'b0;
        end
        for (i = 1; i < 4; i++) begin
            wr(CA, 8'(i * 80));
            wr(MB, 8'h03);
            wr(CN, 8'h00);
            wr(FL, 8'h07);
            pv = {wave_out_a, wave_out_b};
            run(6);
            @(negedge clk);
            chk({4'h0, wave_oe_a, wave_oe_b, match_flag_b, wave_out_b},
                {7'h07, i == 1 ? ~pv[0] : i == 3});
        end
        for (i = 1; i < 4; i++) begin
            wr(CA, 8'(i * 80));
            wr(FL, 8'h07);
            @(negedge clk);
            pv = {wave_out_a, wave_out_b};
            wr(CB, 8'hc0);
            @(negedge clk);
            chk({4'h0, match_flag_a, match_flag_b, wave_out_a, wave_out_b},
                {6'h0, i == 1 ? ~pv : {2{i == 3}}});
        end
        wr(CA, 8'h23);
        @(negedge clk);
        pv[0] = wave_out_b;
        wr(CB, 8'h40);
        @(negedge clk);
        chk({7'h0, wave_out_b}, {7'h0, pv[0]});
        wr(CA, 8'h10);
        wr(MB, 8'h10);
        wr(FL, 8'h07);
        wr(CN, 8'h10);
        run(4);
        @(negedge clk);
        chk({7'h0, match_flag_b}, 8'h00);
        wr(CA, 8'h00);
        wr(CN, 8'hfd);
        wr(FL, 8'h07);
        run(4);
        rd(CN, rv);
        chk({rv[6:0], overflow_flag}, 8'h07);
        @(posedge clk);
        vector_clear <= 3'h1;
        @(posedge clk);
        vector_clear <= 3'h0;
        @(negedge clk);
        chk({7'h0, overflow_flag}, 8'h00);
        wr(MA, 8'h04);
        wr(CA, 8'h02);
        wr(CN, 8'h00);
        wr(FL, 8'h07);
        run(20);
        rd(CN, rv);
        chk({rv[5:0], match_flag_a, overflow_flag}, 8'h0a);
        for (i = 0; i < 4; i++) begin
            rv = 8'h20 + 8'($random(seed) & 32'h7f);
            duty(i[1] ? 3'h1 : 3'h3, {1'b1, i[0]}, rv);
        end
        duty(tw_pkg::MODE_FAST_FF, tw_pkg::ACT_CLEAR, 8'hff);
        duty(tw_pkg::MODE_FAST_FF, tw_pkg::ACT_SET, 8'hff);
        conclude();
    end
endmodule : testbench
